// ---- src/ledcr_pkg.sv ----
// Constants shared by the LED driver control logic
package ledcr_pkg;
	localparam logic [6:0] LEDCR_TARGET_ADDR = 7'h66;
	localparam logic [1:0] LEDCR_OFS_PAIR_A = 2'h0;
	localparam logic [1:0] LEDCR_OFS_PAIR_B = 2'h1;
	localparam logic [1:0] LEDCR_OFS_PAIR_C = 2'h2;
	localparam logic [1:0] LEDCR_OFS_ON_OFF = 2'h3;
	localparam logic [7:0] LEDCR_REG_RESET = 8'h00;
	localparam logic [7:0] LEDCR_USED_MASK = 8'h3F;
	localparam int LEDCR_CLK_HZ = 40000000;
	localparam int LEDCR_STEP_UP_US = 400;
	localparam int LEDCR_STEP_UP_CYC = LEDCR_STEP_UP_US * (LEDCR_CLK_HZ / 1000000);
	localparam int LEDCR_BIT_CNT_LAST = 7;
endpackage

// ---- src/ledcr_serial.sv ----
// Serial bus target: address match, register pointer, reads and writes
`timescale 1ns/1ps
module ledcr_serial
	import ledcr_pkg::*;
(
	input wire logic mclk, // Core clock
	input wire logic rst, // Synchronous reset
	input wire logic scl_in, // Serial clock, synchronised
	input wire logic sda_in, // Serial data, synchronised
	output logic sda_oe, // Pull data line low
	output logic wr_stb, // Register write pulse
	output logic [1:0] wr_addr, // Register written
	output logic [7:0] wr_data, // Data written
	output logic [1:0] rd_addr, // Register to read
	input wire logic [7:0] rd_data // Read value
);
	typedef enum {ST_IDLE, ST_BEGIN, ST_DEVADR, ST_ACK, ST_REGADR,
		ST_WDATA, ST_RDATA, ST_MACK} ledcr_st_type;
	ledcr_st_type st_r, st_nxt, after_r, after_nxt;
	logic scl_d_r, sda_d_r;
	logic [7:0] sh_r, sh_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [1:0] ptr_r, ptr_nxt;
	logic oe_r, oe_nxt;
	logic stb_nxt, stb_r;
	logic [7:0] wd_r, wd_nxt;
	logic rise, fall, start, stop;
	assign rise = scl_in & ~scl_d_r;
	assign fall = ~scl_in & scl_d_r;
	assign start = scl_in & scl_d_r & sda_d_r & ~sda_in;
	assign stop = scl_in & scl_d_r & ~sda_d_r & sda_in;
	assign sda_oe = oe_r;
	assign wr_stb = stb_r;
	assign wr_addr = ptr_r;
	assign wr_data = wd_r;
	assign rd_addr = ptr_r;
	// Next state of the byte engine
	always_comb begin
		st_nxt = st_r;
		after_nxt = after_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		// Pointer steps past each written byte
		ptr_nxt = stb_r ? ptr_r + 2'h1 : ptr_r;
		oe_nxt = oe_r;
		stb_nxt = 1'b0;
		wd_nxt = wd_r;
		if (start) begin
			st_nxt = ST_BEGIN;
			cnt_nxt = 3'h0;
			oe_nxt = 1'b0;
		end else if (stop) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end else begin
			case (st_r)
			// The clock fall that closes a start is not a data bit
			ST_BEGIN: begin
				if (fall) begin
					st_nxt = ST_DEVADR;
					cnt_nxt = 3'h0;
				end
			end
			ST_DEVADR, ST_REGADR, ST_WDATA: begin
				if (rise) begin
					sh_nxt = {sh_r[6:0], sda_in};
				end
				if (fall) begin
					cnt_nxt = cnt_r + 3'h1;
					if (cnt_r == 3'(LEDCR_BIT_CNT_LAST)) begin
						st_nxt = ST_ACK;
						oe_nxt = 1'b1;
						if (st_r == ST_DEVADR) begin
							if (sh_r[7:1] != LEDCR_TARGET_ADDR) begin // RQ15
								st_nxt = ST_IDLE;
								oe_nxt = 1'b0;
							end else if (sh_r[0]) begin // RQ17
								after_nxt = ST_RDATA;
							end else begin
								after_nxt = ST_REGADR;
							end
						end else if (st_r == ST_REGADR) begin
							ptr_nxt = sh_r[1:0]; // RQ2
							after_nxt = ST_WDATA;
						end else begin
							wd_nxt = sh_r;
							stb_nxt = 1'b1;
							after_nxt = ST_WDATA;
						end
					end
				end
			end
			ST_ACK: begin
				if (fall) begin
					st_nxt = after_r;
					cnt_nxt = 3'h0;
					oe_nxt = 1'b0;
					if (after_r == ST_RDATA) begin
						sh_nxt = rd_data; // RQ6
						oe_nxt = ~rd_data[7];
					end else if (st_r == ST_ACK && after_r == ST_WDATA
						&& ptr_r != LEDCR_OFS_ON_OFF) begin
						ptr_nxt = ptr_r;
					end
				end
			end
			ST_RDATA: begin
				if (fall) begin
					cnt_nxt = cnt_r + 3'h1;
					sh_nxt = {sh_r[6:0], 1'b0};
					oe_nxt = ~sh_r[6];
					if (cnt_r == 3'(LEDCR_BIT_CNT_LAST)) begin
						st_nxt = ST_MACK;
						oe_nxt = 1'b0;
					end
				end
			end
			ST_MACK: begin
				// Master ack continues, nack ends the read
				if (rise) begin
					if (sda_in) begin
						st_nxt = ST_IDLE;
						after_nxt = ST_IDLE;
					end else begin
						ptr_nxt = ptr_r + 2'h1;
						after_nxt = ST_RDATA;
					end
				end
				if (fall && after_r == ST_RDATA && st_r == ST_MACK) begin
					st_nxt = ST_RDATA;
					cnt_nxt = 3'h0;
					sh_nxt = rd_data;
					oe_nxt = ~rd_data[7];
				end
			end
			default: begin
				oe_nxt = 1'b0;
			end
			endcase
		end
	end
	// Register the engine
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= ST_IDLE;
			after_r <= ST_IDLE;
			sh_r <= 8'h00;
			cnt_r <= 3'h0;
			ptr_r <= 2'h0;
			oe_r <= 1'b0;
			stb_r <= 1'b0;
			wd_r <= 8'h00;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			after_r <= after_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			ptr_r <= ptr_nxt;
			oe_r <= oe_nxt;
			stb_r <= stb_nxt;
			wd_r <= wd_nxt;
			scl_d_r <= scl_in;
			sda_d_r <= sda_in;
		end
	end
endmodule // ledcr_serial

// ---- src/ledcr_top.sv ----
// LED driver control registers, shutdown and pump mode sequencing
// Operation
// RQ1 - Four eight-bit registers: three pair currents and one on/off.
// RQ2 - Addresses 0,1,2 pair A,B,C current; 3 on/off register.
// RQ3 - Current registers: bits 7,6 unused, low six bits set pair code.
// RQ4 - On/off bits 0..5 drive A1,A2,B1,B2,C1,C2; one means on.
// RQ5 - Each on/off bit gates its own channel only.
// RQ6 - Data line bidirectional; all four registers write and read back.
// RQ7 - After enable rises every channel current stays zero until programmed.
// RQ8 - Enable low holds zero-current shutdown; host keeps it low.
// RQ9 - In shutdown every channel output is high impedance, no current.
// RQ10 - Supply below threshold disables all six channels.
// RQ11 - Pump starts in 1x and stays while regulation holds.
// RQ12 - Regulation lost in 1x: go 1.5x after fixed 400 us.
// RQ13 - Restart mode choice at power-up, enable rise, on/off write.
// RQ14 - Host should switch off channels without an attached LED.
// RQ15 - Answer only to fixed target address 1100110.
// RQ16 - Code N gives 0.5 mA times N plus one.
// RQ17 - Read: address write, repeated start, read byte, nack, stop.
// RQ18 - Bus rates up to 400 kbit/s supported.
// RQ19 - All registers clear at power-up and while enable low.
// RQ20 - Upper two bits ignore writes and read back zero.
`timescale 1ns/1ps
module ledcr_top
	import ledcr_pkg::*;
#(
	parameter int STEP_UP_CYC = LEDCR_STEP_UP_CYC
) (
	input wire logic mclk, // Core clock, 40 MHz
	input wire logic rst, // Power-up reset
	input wire logic enable_pin, // Enable input, async
	input wire logic scl_pin, // Serial clock pin
	input wire logic sda_in, // Serial data pin level
	output logic sda_out, // Serial data drive value
	output logic sda_oe, // Serial data drive enable
	input wire logic supply_low_lockout, // Supply under threshold, async
	input wire logic reg_fail, // Currents not held in 1x, async
	output logic pump_boost, // 1 = 1.5x mode, 0 = 1x
	output logic [5:0] code_a, // Pair A current code
	output logic [5:0] code_b, // Pair B current code
	output logic [5:0] code_c, // Pair C current code
	output logic [5:0] sink_on, // Channel sink active
	output logic [5:0] sink_hiz // Channel sink high impedance
);
	logic en_m_r, en_r, scl_m_r, scl_r, sda_m_r, sda_r;
	logic uv_m_r, uv_r, rf_m_r, rf_r, en_d_r;
	logic [7:0] regs_r [4];
	logic [7:0] regs_nxt [4];
	logic wr_stb, soe;
	logic [1:0] wr_addr, rd_addr;
	logic [7:0] wr_data;
	logic boost_r, boost_nxt;
	logic [31:0] wait_r, wait_nxt;
	logic restart, core_rst, active;
	logic [5:0] sink_on_nxt, sink_hiz_nxt, sink_on_r, sink_hiz_r;
	// Two-stage synchronisers for all pin inputs; RQ18 margin at 40 MHz
	always_ff @(posedge mclk) begin
		if (rst) begin
			en_m_r <= 1'b0;
			en_r <= 1'b0;
			scl_m_r <= 1'b1;
			scl_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_r <= 1'b1;
			uv_m_r <= 1'b0;
			uv_r <= 1'b0;
			rf_m_r <= 1'b0;
			rf_r <= 1'b0;
			en_d_r <= 1'b0;
		end else begin
			en_m_r <= enable_pin;
			en_r <= en_m_r;
			scl_m_r <= scl_pin;
			scl_r <= scl_m_r;
			sda_m_r <= sda_in;
			sda_r <= sda_m_r;
			uv_m_r <= supply_low_lockout;
			uv_r <= uv_m_r;
			rf_m_r <= reg_fail;
			rf_r <= rf_m_r;
			en_d_r <= en_r;
		end
	end
	// Serial engine held in reset during shutdown
	assign core_rst = rst | ~en_r; // RQ8
	ledcr_serial u_serial (
		.mclk(mclk),
		.rst(core_rst),
		.scl_in(scl_r),
		.sda_in(sda_r),
		.sda_oe(soe),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(regs_r[rd_addr])
	);
	// Open-drain: only ever drive low
	assign sda_out = 1'b0; // RQ6
	assign sda_oe = soe;
	// Register file next values
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			regs_nxt[i] = regs_r[i];
		end
		if (wr_stb) begin
			regs_nxt[wr_addr] = wr_data & LEDCR_USED_MASK; // RQ1 RQ20
		end
	end
	// Registers clear in shutdown so channels come up dark
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 4; i++) begin
			if (core_rst) begin
				regs_r[i] <= LEDCR_REG_RESET; // RQ19 RQ7
			end else begin
				regs_r[i] <= regs_nxt[i];
			end
		end
	end
	// Only the low six bits of a register reach the sinks
	function automatic logic [5:0] used_bits(input logic [7:0] value);
		used_bits = value[5:0];
	endfunction
	// Code drives both channels of a pair; analogue maps N to 0.5*(N+1) mA
	assign code_a = used_bits(regs_r[LEDCR_OFS_PAIR_A]); // RQ3 RQ16
	assign code_b = used_bits(regs_r[LEDCR_OFS_PAIR_B]); // RQ3
	assign code_c = used_bits(regs_r[LEDCR_OFS_PAIR_C]); // RQ3
	// Lockout overrides the on/off bits without touching them
	assign active = en_r & ~uv_r;
	// Per-channel gate; bit order A1,A2,B1,B2,C1,C2
	always_comb begin
		sink_on_nxt = used_bits(regs_r[LEDCR_OFS_ON_OFF]); // RQ4 RQ5
		if (!active) begin
			sink_on_nxt = 6'h00; // RQ10
		end
		sink_hiz_nxt = {6{~en_r}}; // RQ9
	end
	// Sinks registered on one edge so on and high-impedance never overlap
	always_ff @(posedge mclk) begin
		if (rst) begin
			sink_on_r <= 6'h00;
			sink_hiz_r <= 6'h3F;
		end else begin
			sink_on_r <= sink_on_nxt;
			sink_hiz_r <= sink_hiz_nxt;
		end
	end
	assign sink_on = sink_on_r;
	assign sink_hiz = sink_hiz_r;
	// Mode choice restarts on enable rise or on/off write
	assign restart = (en_r & ~en_d_r)
		| (wr_stb & (wr_addr == LEDCR_OFS_ON_OFF)); // RQ13
	always_comb begin
		boost_nxt = boost_r;
		wait_nxt = wait_r;
		if (restart | ~active) begin
			boost_nxt = 1'b0; // RQ11
			wait_nxt = 32'h0;
		end else if (!boost_r) begin
			if (rf_r) begin
				// Deficit must persist the whole wait before stepping up
				if (wait_r >= 32'(STEP_UP_CYC - 1)) begin
					boost_nxt = 1'b1; // RQ12
				end else begin
					wait_nxt = wait_r + 32'h1;
				end
			end else begin
				wait_nxt = 32'h0;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			boost_r <= 1'b0;
			wait_r <= 32'h0;
		end else begin
			boost_r <= boost_nxt;
			wait_r <= wait_nxt;
		end
	end
	assign pump_boost = boost_r;
endmodule // ledcr_top

// ---- verification/ledcr_top_asserts.sv ----
// Port checks for the LED driver control
`timescale 1ns/1ps
module ledcr_top_chk #(
	parameter int STEP_UP_CYC = 20
) (
	input wire logic mclk, // Clock
	input wire logic rst, // Reset
	input wire logic enable_pin, // Enable
	input wire logic supply_low_lockout, // Supply low
	input wire logic reg_fail, // Regulation lost
	input wire logic sda_out, // Data value
	input wire logic sda_oe, // Data pull
	input wire logic pump_boost, // Pump mode
	input wire logic [5:0] code_a, // Pair A
	input wire logic [5:0] sink_on, // Sinks on
	input wire logic [5:0] sink_hiz // Sinks off
);
	logic [31:0] fail_r, fail_nxt;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Raw pin count; it leads the synced count, so a lower bound
	always_comb fail_nxt = reg_fail ? fail_r + 32'h1 : 32'h0;
	always_ff @(posedge mclk) fail_r <= rst ? 32'h0 : fail_nxt;
	drain_only_a: assert property (sda_out == 1'b0)
		else $error("data driven high");
	reset_state_a: assert property (disable iff (1'b0) rst |=>
		!pump_boost && sink_on == 6'h00 && code_a == 6'h00)
		else $error("reset state");
	hiz_excl_a: assert property ((sink_on & sink_hiz) == 6'h00)
		else $error("sink on while off");
	lock_off_a: assert property (supply_low_lockout [*6] |->
		sink_on == 6'h00 && !pump_boost) else $error("lockout");
	shut_state_a: assert property (!enable_pin [*6] |->
		sink_hiz == 6'h3F && code_a == 6'h00 && !pump_boost)
		else $error("shutdown");
	wake_drive_a: assert property (enable_pin [*6] |-> !sink_hiz)
		else $error("sinks stay off");
	wake_zero_a: assert property ($fell(sink_hiz[0]) |->
		sink_on == 6'h00 && code_a == 6'h00) else $error("wake current");
	boost_gate_a: assert property ($rose(pump_boost) |->
		fail_r >= STEP_UP_CYC) else $error("early step up");
	ack_quiet_a: assert property (!enable_pin [*4] |-> !sda_oe)
		else $error("bus answered in shutdown");
	c_boost: cover property ($rose(pump_boost));
	c_all_on: cover property (sink_on == 6'h3F);
	c_ack: cover property ($rose(sda_oe));
endmodule // ledcr_top_chk

bind ledcr_top ledcr_top_chk #(.STEP_UP_CYC(STEP_UP_CYC)) u_chk (
	.mclk(mclk), .rst(rst), .enable_pin(enable_pin), .sda_out(sda_out),
	.supply_low_lockout(supply_low_lockout), .reg_fail(reg_fail),
	.sda_oe(sda_oe), .pump_boost(pump_boost), .code_a(code_a),
	.sink_on(sink_on), .sink_hiz(sink_hiz));

// ---- verification/ledcr_host.sv ----
// Serial bus master model, open-drain data
`timescale 1ns/1ps
module ledcr_host (
	input wire logic mclk, // Core clock
	input wire logic sda_line, // Resolved data line
	output logic scl = 1'b1, // Serial clock, idle high
	output logic sda_m = 1'b1 // Data, 1 releases
);
	// Lines move just after a core edge, then hold a quarter period
	task automatic drv(input logic c, input logic d);
		scl <= c;
		sda_m <= d;
		repeat (2) @(posedge mclk);
	endtask
	task automatic start;
		drv(1'b0, 1'b1);
		drv(1'b1, 1'b1);
		drv(1'b1, 1'b0);
		drv(1'b0, 1'b0);
	endtask
	// Data rises while the clock is high: stop
	task automatic stop;
		drv(1'b0, 1'b0);
		drv(1'b1, 1'b0);
		drv(1'b1, 1'b1);
	endtask
	// Data set while clock low, sampled mid-high
	task automatic bitx(input logic b, output logic r);
		drv(1'b0, b);
		drv(1'b1, b);
		r = sda_line;
		drv(1'b1, b);
		drv(1'b0, b);
	endtask
	// MSB first; ninth bit released for the acknowledge
	task automatic xfer(input logic [7:0] d, output logic [7:0] r,
		output logic a);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], b);
			r[i] = b;
		end
		bitx(1'b1, b);
		a = ~b;
	endtask
	task automatic xact(input logic [6:0] dev, input logic rnw,
		input logic [7:0] ra, input logic [7:0] wd, output logic [7:0] rd,
		output logic ok);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		a2 = 1'b1;
		start;
		xfer({dev, 1'b0}, r, a0);
		xfer(ra, r, a1);
		if (rnw) begin
			start;
			xfer({dev, 1'b1}, r, a2);
		end
		xfer(rnw ? 8'hFF : wd, rd, a3);
		stop;
		ok = a0 & a1 & a2 & (rnw | a3);
	endtask
endmodule // ledcr_host

// ---- verification/tb_top.sv ----
// Bench: registers, shutdown, lockout, pump step-up
`timescale 1ns/1ps
module tb_top;
	import ledcr_pkg::*;
	localparam int STEP = 20;
	logic mclk, rst, enable_pin, supply_low_lockout, reg_fail, scl, sda_m;
	logic sda_out, sda_oe, pump_boost, ok;
	logic [5:0] code_a, code_b, code_c, sink_on, sink_hiz;
	logic [7:0] wv [4] = '{8'hFF, 8'hC1, 8'h7E, 8'hE5};
	int err_count = 0;
	int samples_checked = 0;
	wire sda_line;
	// Pull-up: high unless a party pulls low
	assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
	ledcr_host u_host (.mclk(mclk), .sda_line(sda_line), .scl(scl),
		.sda_m(sda_m));
	ledcr_top #(.STEP_UP_CYC(STEP)) u_dut (.mclk(mclk), .rst(rst),
		.enable_pin(enable_pin), .scl_pin(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe),
		.supply_low_lockout(supply_low_lockout), .reg_fail(reg_fail),
		.pump_boost(pump_boost), .code_a(code_a), .code_b(code_b),
		.code_c(code_c), .sink_on(sink_on), .sink_hiz(sink_hiz));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Values are captured at the call; only the compare waits 1 ns
	task automatic chk(input string n, input logic [23:0] e,
		input logic [23:0] g);
		#1;
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] a,
		input logic [7:0] d);
		logic [7:0] r;
		u_host.xact(dev, 1'b0, a, d, r, ok);
		chk("ack", dev == LEDCR_TARGET_ADDR, ok);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		u_host.xact(LEDCR_TARGET_ADDR, 1'b1, a, 8'h00, r, ok);
		chk("read", e, r);
	endtask
	// Two data bytes in one frame; the pointer must step between them
	task automatic wr2(input logic [7:0] a, input logic [7:0] d0,
		input logic [7:0] d1);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		u_host.start;
		u_host.xfer({LEDCR_TARGET_ADDR, 1'b0}, r, a0);
		u_host.xfer(a, r, a1);
		u_host.xfer(d0, r, a2);
		u_host.xfer(d1, r, a3);
		u_host.stop;
		chk("burst ack", 1, a0 & a1 & a2 & a3);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Run needs about 0.085 ms
	initial begin
		#1000000;
		err_count++;
		complete_run;
	end
	initial begin
		rst = 1'b1;
		enable_pin = 1'b1;
		supply_low_lockout = 1'b0;
		reg_fail = 1'b0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
		chk("wake", 0, {sink_hiz, sink_on});
		// Upper bits set in every write must be dropped
		// Channels with no LED (A2, B2, C1) are left switched off
		for (int i = 0; i < 4; i++) begin
			wr(LEDCR_TARGET_ADDR, 8'(i), wv[i]);
		end
		for (int i = 0; i < 4; i++) begin
			rd(8'(i), wv[i] & LEDCR_USED_MASK);
		end
		chk("codes", {6'h3F, 6'h01, 6'h3E}, {code_a, code_b, code_c});
		chk("sinks", 6'h25, sink_on);
		wr(7'h67, 8'h00, 8'h00);
		chk("foreign", 6'h3F, code_a);
		wr2(8'h01, 8'h05, 8'h46);
		chk("burst", {6'h05, 6'h06}, {code_b, code_c});
		// Step-up only after the full wait
		reg_fail <= 1'b1;
		repeat (STEP - 1) @(posedge mclk);
		chk("pump early", 0, pump_boost);
		repeat (9) @(posedge mclk);
		chk("pump boost", 1, pump_boost);
		reg_fail <= 1'b0;
		wr(LEDCR_TARGET_ADDR, 8'h03, 8'h3F);
		chk("restart", 6'h3F, {pump_boost, sink_on});
		reg_fail <= 1'b1;
		repeat (STEP + 8) @(posedge mclk);
		supply_low_lockout <= 1'b1;
		repeat (6) @(posedge mclk);
		chk("lockout", 0, {pump_boost, sink_on});
		supply_low_lockout <= 1'b0;
		reg_fail <= 1'b0;
		repeat (6) @(posedge mclk);
		chk("unlock", 6'h3F, {pump_boost, sink_on});
		enable_pin <= 1'b0;
		repeat (8) @(posedge mclk);
		chk("shutdown", 12'hFC0, {sink_hiz, sink_on});
		enable_pin <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("rewake", 0, {pump_boost, sink_hiz, code_a});
		rd(8'h03, 8'h00);
		complete_run;
	end
endmodule // tb_top
